// File: verilog/chan_mux_pkg.sv
package chan_mux_pkg;

	localparam int          ADDR_W       = 7;
	localparam int          BYTE_W       = 8;
	localparam int          NUM_PAIRS    = 4;
	localparam logic [3:0]  BIT_COUNT    = 4'h8;
	localparam logic [3:0]  CNT_ZERO     = 4'h0;
	localparam logic [3:0]  CNT_ONE      = 4'h1;
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [6:0]  ADDR_DEFAULT = 7'h70;
	localparam int          EN_BIT       = 2;
	localparam int          SEL_LSB      = 0;
	localparam int          SEL_MSB      = 1;
	localparam int          RW_BIT       = 0;
	localparam int          MSB_BIT      = 7;

	typedef enum logic [2:0] {
		S_IDLE     = 3'b000,
		S_ADDR     = 3'b001,
		S_ADDR_ACK = 3'b010,
		S_WR_DATA  = 3'b011,
		S_WR_ACK   = 3'b100,
		S_RD_DATA  = 3'b101,
		S_RD_ACK   = 3'b110
	} serial_state_t;

	// Bit 2 enables a connection, bits 1:0 pick the pair; upper bits never matter.
	function automatic logic [NUM_PAIRS-1:0] sel_decode(input logic [BYTE_W-1:0] ctrl);
		logic [NUM_PAIRS-1:0] onehot;
		onehot = '0;
		if (ctrl[EN_BIT]) begin
			onehot[ctrl[SEL_MSB:SEL_LSB]] = 1'b1;
		end
		return onehot;
	endfunction : sel_decode

endpackage : chan_mux_pkg

// File: verilog/line_sync.sv
`timescale 1ns/1ps
`default_nettype none

module line_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_arst_n,
	input  wire logic             i_ce,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// Lines idle high, so the chain resets high to avoid a false edge at release.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_q <= '1;
			sync_q <= '1;
		end else if (i_ce) begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule : line_sync
`default_nettype wire

// File: verilog/chan_mux_ctrl.sv
// Function
// - Write starts with matching address and direction zero; address byte is acknowledged.
// - Each byte following the address is taken as the control byte; bits 2:0 select.
// - Bits 7 to 3 of the control byte never affect pair selection.
// - Any number of written bytes accepted; the last before STOP counts.
// - A new selection connects nothing until the following STOP condition.
// - Read address with direction one is acknowledged, then control byte is driven.
// - Control byte repeats while the master acknowledges; a NACK ends the read.
// - No limit on the number of bytes returned in one read.
// - Readback bits 2:0 show the channel set by the latest write.
// - Bit 2 enables; bits 1:0 pick one pair; at most one connected.
// - Reset clears control byte, idles the state machine, disconnects all pairs.
`timescale 1ns/1ps
`default_nettype none

module chan_mux_ctrl
	import chan_mux_pkg::*;
#(
	parameter logic [ADDR_W-1:0] SLAVE_ADDR = ADDR_DEFAULT
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_arst_n,
	input  wire logic                 i_ce,
	input  wire logic                 i_scl,
	input  wire logic                 i_sda,
	output logic                      o_sda_out,
	output logic                      o_sda_oe_n,
	output logic [NUM_PAIRS-1:0]      o_pair_connect,
	output logic [BYTE_W-1:0]         o_channel_select
);

	logic                 scl_s;
	logic                 sda_s;
	logic                 scl_q;
	logic                 sda_q;
	serial_state_t        state_q;
	serial_state_t        state_d;
	logic [3:0]           cnt_q;
	logic [3:0]           cnt_d;
	logic [BYTE_W-1:0]    shift_q;
	logic [BYTE_W-1:0]    shift_d;
	logic                 drive_q;
	logic                 drive_d;
	logic                 ack_q;
	logic                 ack_d;
	logic [BYTE_W-1:0]    pending_q;
	logic [BYTE_W-1:0]    pending_d;
	logic                 pending_vld_q;
	logic                 pending_vld_d;
	logic [BYTE_W-1:0]    channel_select_q;
	logic [NUM_PAIRS-1:0] pair_connect_q;

	line_sync #(.WIDTH(2)) u_sync (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_ce     (i_ce),
		.i_async  ({i_scl, i_sda}),
		.o_sync   ({scl_s, sda_s})
	);

	wire scl_rise  = i_ce & scl_s & ~scl_q;
	wire scl_fall  = i_ce & ~scl_s & scl_q;
	wire start_evt = i_ce & scl_s & scl_q & sda_q & ~sda_s;
	wire stop_evt  = i_ce & scl_s & scl_q & ~sda_q & sda_s;
	wire byte_done = (cnt_q == BIT_COUNT);
	wire addr_hit  = (shift_q[BYTE_W-1:1] == SLAVE_ADDR);
	wire rw_read   = shift_q[RW_BIT];

	always_comb begin
		state_d       = state_q;
		cnt_d         = cnt_q;
		shift_d       = shift_q;
		drive_d       = drive_q;
		ack_d         = ack_q;
		pending_d     = pending_q;
		pending_vld_d = pending_vld_q;
		if (start_evt) begin
			state_d = S_ADDR;
			cnt_d   = CNT_ZERO;
			drive_d = 1'b0;
		end else if (stop_evt) begin
			state_d       = S_IDLE;
			drive_d       = 1'b0;
			pending_vld_d = 1'b0;
		end else if (scl_rise) begin
			case (state_q)
				S_ADDR, S_WR_DATA: begin
					shift_d = {shift_q[BYTE_W-2:0], sda_s};
					cnt_d   = cnt_q + CNT_ONE;
				end
				S_RD_DATA: begin
					cnt_d = cnt_q + CNT_ONE;
				end
				S_RD_ACK: begin
					ack_d = ~sda_s;
				end
				default: begin
					cnt_d = cnt_q;
				end
			endcase
		end else if (scl_fall) begin
			case (state_q)
				S_ADDR: begin
					if (byte_done) begin
						state_d = addr_hit ? S_ADDR_ACK : S_IDLE;
						drive_d = addr_hit;
					end
				end
				S_ADDR_ACK: begin
					cnt_d = CNT_ZERO;
					if (rw_read) begin
						state_d = S_RD_DATA;
						drive_d = ~channel_select_q[MSB_BIT];
						shift_d = {channel_select_q[BYTE_W-2:0], 1'b0};
					end else begin
						state_d = S_WR_DATA;
						drive_d = 1'b0;
					end
				end
				S_WR_DATA: begin
					if (byte_done) begin
						pending_d     = shift_q;
						pending_vld_d = 1'b1;
						state_d       = S_WR_ACK;
						drive_d       = 1'b1;
					end
				end
				S_WR_ACK: begin
					state_d = S_WR_DATA;
					cnt_d   = CNT_ZERO;
					drive_d = 1'b0;
				end
				S_RD_DATA: begin
					if (byte_done) begin
						state_d = S_RD_ACK;
						drive_d = 1'b0;
					end else begin
						drive_d = ~shift_q[MSB_BIT];
						shift_d = {shift_q[BYTE_W-2:0], 1'b0};
					end
				end
				S_RD_ACK: begin
					if (ack_q) begin
						state_d = S_RD_DATA;
						cnt_d   = CNT_ZERO;
						drive_d = ~channel_select_q[MSB_BIT];
						shift_d = {channel_select_q[BYTE_W-2:0], 1'b0};
					end else begin
						state_d = S_IDLE;
					end
				end
				default: begin
					state_d = S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			scl_q         <= 1'b1;
			sda_q         <= 1'b1;
			state_q       <= S_IDLE;
			cnt_q         <= CNT_ZERO;
			shift_q       <= CTRL_RESET;
			drive_q       <= 1'b0;
			ack_q         <= 1'b0;
			pending_q     <= CTRL_RESET;
			pending_vld_q <= 1'b0;
		end else if (i_ce) begin
			scl_q         <= scl_s;
			sda_q         <= sda_s;
			state_q       <= state_d;
			cnt_q         <= cnt_d;
			shift_q       <= shift_d;
			drive_q       <= drive_d;
			ack_q         <= ack_d;
			pending_q     <= pending_d;
			pending_vld_q <= pending_vld_d;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			channel_select_q <= CTRL_RESET;
			pair_connect_q   <= '0;
		end else if (stop_evt && pending_vld_q) begin
			channel_select_q <= pending_q;
			pair_connect_q   <= sel_decode(pending_q);
		end
	end

	// The line is open drain: the pad only ever pulls low.
	assign o_sda_out        = 1'b0;
	assign o_sda_oe_n       = ~drive_q;
	assign o_pair_connect   = pair_connect_q;
	assign o_channel_select = channel_select_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	a_addr_ack_match: assert property (
		scl_fall && state_q == S_ADDR && byte_done && addr_hit
		|=> state_q == S_ADDR_ACK && !o_sda_oe_n)
		else $error("matching address not acknowledged");

	a_addr_nack_miss: assert property (
		scl_fall && state_q == S_ADDR && byte_done && !addr_hit
		|=> state_q == S_IDLE && o_sda_oe_n)
		else $error("foreign address acknowledged");

	a_write_byte_kept: assert property (
		scl_fall && state_q == S_WR_DATA && byte_done
		|=> pending_vld_q && pending_q == $past(shift_q) && !o_sda_oe_n)
		else $error("written byte not held as pending");

	a_hold_until_stop: assert property (
		!(stop_evt && pending_vld_q) |=> $stable(o_pair_connect) && $stable(o_channel_select))
		else $error("selection changed without STOP");

	a_stop_commit_sel: assert property (
		stop_evt && pending_vld_q
		|=> o_pair_connect == ($past(pending_q[EN_BIT])
			? ({{(NUM_PAIRS-1){1'b0}}, 1'b1} << $past(pending_q[SEL_MSB:SEL_LSB]))
			: '0)
			&& o_channel_select == $past(pending_q))
		else $error("STOP did not commit the last byte");

	a_single_pair: assert property (
		$onehot0(o_pair_connect) && ((o_pair_connect != '0) == o_channel_select[EN_BIT]))
		else $error("pair connection disagrees with enable bit");

	a_read_first_bit: assert property (
		scl_fall && state_q == S_ADDR_ACK && rw_read
		|=> state_q == S_RD_DATA && o_sda_oe_n == o_channel_select[MSB_BIT])
		else $error("readback first bit wrong");

	a_read_repeat: assert property (
		scl_fall && state_q == S_RD_ACK
		|=> (state_q == S_RD_DATA) == $past(ack_q) ##0 (state_q == S_RD_DATA || o_sda_oe_n))
		else $error("read did not repeat on ACK or stop on NACK");

	c_write_commit: cover property (stop_evt && pending_vld_q && pending_q[EN_BIT]);
	c_read_repeat:  cover property (scl_fall && state_q == S_RD_ACK && ack_q);
	c_addr_miss:    cover property (scl_fall && state_q == S_ADDR && byte_done && !addr_hit);

endmodule : chan_mux_ctrl
`default_nettype wire

// File: verification/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
	output logic      o_scl,
	output logic      o_sda_drv,
	input  wire logic i_sda
);

	initial begin
		o_scl = 1'b1;
		o_sda_drv = 1'b1;
	end

	// Every step is a whole number of system clocks, so a caller that starts just after an
	// edge keeps every pin change off the sampling edges of the slave's synchronisers.
	task automatic clk_bit(input logic b, output logic s);
		#40 o_sda_drv = b;
		#60 o_scl = 1'b1;
		#40 s = i_sda;
		#20 o_scl = 1'b0;
	endtask : clk_bit

	task automatic start();
		#80 o_sda_drv = 1'b0;
		#80 o_scl = 1'b0;
	endtask : start

	task automatic stop();
		#40 o_sda_drv = 1'b0;
		#60 o_scl = 1'b1;
		#80 o_sda_drv = 1'b1;
		#80;
	endtask : stop

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], s);
		end
		clk_bit(1'b1, s);
		ack = ~s;
	endtask : wbyte

	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, d[i]);
		end
		clk_bit(~ack, s);
	endtask : rbyte

endmodule : bus_master_model
`default_nettype wire

// File: verification/chan_mux_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none

module chan_mux_ctrl_test;
	import chan_mux_pkg::*;

	logic                 i_clk = 1'b0;
	logic                 i_arst_n;
	logic                 ce;
	logic                 scl;
	logic                 mst_sda;
	logic                 sda_out;
	logic                 sda_oe_n;
	logic                 ack;
	logic [NUM_PAIRS-1:0] pair;
	logic [BYTE_W-1:0]    chan;
	logic [BYTE_W-1:0]    rd;
	logic [BYTE_W-1:0]    last;
	logic [BYTE_W-1:0]    prev;
	logic [15:0]          lfsr;
	int                   fails = 0;
	int                   tests_run = 0;
	int                   cycles = 0;
	int                   n;
	// The bus is pulled up; either party may pull it low.
	wire                  sda = mst_sda & (sda_oe_n | sda_out);

	always #10 i_clk = ~i_clk;

	chan_mux_ctrl #(.SLAVE_ADDR(ADDR_DEFAULT)) dut_u (
		.i_clk            (i_clk),
		.i_arst_n         (i_arst_n),
		.i_ce             (ce),
		.i_scl            (scl),
		.i_sda            (sda),
		.o_sda_out        (sda_out),
		.o_sda_oe_n       (sda_oe_n),
		.o_pair_connect   (pair),
		.o_channel_select (chan)
	);

	bus_master_model mst_u (
		.o_scl     (scl),
		.o_sda_drv (mst_sda),
		.i_sda     (sda)
	);

	function automatic logic [15:0] next_rand(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : next_rand

	function automatic logic [3:0] exp_pair(input logic [7:0] c);
		return c[2] ? (4'h1 << c[1:0]) : 4'h0;
	endfunction : exp_pair

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			final_report();
		end
	end

	initial begin
		i_arst_n = 1'b0;
		ce = 1'b1;
		lfsr = 16'h6675;
		prev = 8'h00;
		repeat (3) @(posedge i_clk);
		#1 i_arst_n = 1'b1;
		repeat (3) @(posedge i_clk);
		// Every pin change below stays one step after a rising edge.
		#1;
		chk(chan, 8'h00);
		chk({pair, 3'h0, sda_oe_n}, 8'h01);
		// Codes 0 to 7 in the select field, then one foreign address.
		for (int k = 0; k < 9; k++) begin
			lfsr = next_rand(lfsr);
			n = int'(lfsr[9:8]);
			mst_u.start();
			mst_u.wbyte({(k < 8) ? ADDR_DEFAULT : ADDR_DEFAULT ^ 7'h01, 1'b0}, ack);
			chk({7'h00, ack}, (k < 8) ? 8'h01 : 8'h00);
			for (int i = 0; i <= n; i++) begin
				lfsr = next_rand(lfsr);
				last = (i == n) ? {lfsr[7:3], 3'(k)} : lfsr[7:0];
				mst_u.wbyte(last, ack);
			end
			chk(chan, prev);
			chk({4'h0, pair}, {4'h0, exp_pair(prev)});
			mst_u.stop();
			if (k < 8)
				prev = last;
			chk(chan, prev);
			chk({4'h0, pair}, {4'h0, exp_pair(prev)});
			mst_u.start();
			mst_u.wbyte({ADDR_DEFAULT, 1'b1}, ack);
			chk({7'h00, ack}, 8'h01);
			for (int j = 0; j <= n + 2; j++) begin
				mst_u.rbyte(j != n + 2, rd);
				chk(rd, prev);
			end
			mst_u.stop();
			chk({7'h00, sda_oe_n}, 8'h01);
			$display("test %0d done", k);
		end
		// With the enable low the block is frozen and must ignore a whole write.
		ce = 1'b0;
		mst_u.start();
		mst_u.wbyte({ADDR_DEFAULT, 1'b0}, ack);
		chk({7'h00, ack}, 8'h00);
		mst_u.wbyte(prev ^ 8'h04, ack);
		mst_u.stop();
		ce = 1'b1;
		chk(chan, prev);
		chk({4'h0, pair}, {4'h0, exp_pair(prev)});
		$display("enable test done");
		@(posedge i_clk);
		#1 i_arst_n = 1'b0;
		#1 chk(chan, 8'h00);
		chk({pair, 3'h0, sda_oe_n}, 8'h01);
		$display("reset test done");
		final_report();
	end

endmodule : chan_mux_ctrl_test
`default_nettype wire
